// ### design/tcp_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define TCP_ADDR_COUNT    3'h0
`define TCP_ADDR_COMPARE  3'h1
`define TCP_ADDR_CONTROL  3'h2
`define TCP_ADDR_FLAG     3'h3
`define TCP_ADDR_MASK     3'h4

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TCP_CTL_CSEL_LSB  0
`define TCP_CTL_WAVE_LSB  3
`define TCP_CTL_ACT_LSB   5
`define TCP_CTL_FORCE_BIT 7
`define TCP_FLAG_OVF_BIT  0
`define TCP_FLAG_CMP_BIT  1

// ----------------------------------------------------------------------
// count limits and reset values
// ----------------------------------------------------------------------
`define TCP_MAX           8'hff
`define TCP_BOTTOM        8'h00
`define TCP_RST_BYTE      8'h00
`define TCP_RST_PRESCALE  10'h000

// ----------------------------------------------------------------------
// prescaler taps, as bits of the free running divider
// ----------------------------------------------------------------------
`define TCP_DIV8_BITS     3
`define TCP_DIV64_BITS    6
`define TCP_DIV256_BITS   8
`define TCP_DIV1024_BITS  10

`endif

// ### design/tcp_pkg.sv
// types shared by the timer block and its clock select
package tcp_pkg;

  // ----------------------------------------------------------------------
  // plain data types
  // ----------------------------------------------------------------------
  typedef logic [7:0] tcp_byte_t;   // one register byte
  typedef logic [2:0] tcp_addr_t;   // register index

  // ----------------------------------------------------------------------
  // waveform modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TCP_WAVE_NORMAL = 2'b00,
    TCP_WAVE_PHASE  = 2'b01,
    TCP_WAVE_CTC    = 2'b10,
    TCP_WAVE_FAST   = 2'b11
  } tcp_wave_e;

  // ----------------------------------------------------------------------
  // tick sources
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    TCP_CSEL_STOP    = 3'b000,
    TCP_CSEL_DIV1    = 3'b001,
    TCP_CSEL_DIV8    = 3'b010,
    TCP_CSEL_DIV64   = 3'b011,
    TCP_CSEL_DIV256  = 3'b100,
    TCP_CSEL_DIV1024 = 3'b101,
    TCP_CSEL_FALL    = 3'b110,
    TCP_CSEL_RISE    = 3'b111
  } tcp_csel_e;

endpackage

// ### design/tcp_clock_select.sv
// tick source: prescaler taps or synchronised external count edges
`timescale 1ns/1ns
`include "tcp_defs.svh"
module tcp_clock_select #(
  parameter int PRESCALE_WIDTH = 10  // divider length in bits
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire tcp_pkg::tcp_csel_e clock_source_select,
  input  wire logic              ext_pin,
  output logic                   timer_tick
);
  import tcp_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  if (PRESCALE_WIDTH != 10) begin : g_chk
    $error("prescaler must be ten bits wide for the documented taps");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [9:0] pre;    // free running divider
    logic       sync1;  // first synchroniser stage
    logic       sync2;  // second synchroniser stage
    logic       last;   // previous synchronised level
    logic       tick;   // registered tick
  } tcp_csel_s;

  tcp_csel_s st_reg;    // registered state
  tcp_csel_s st_next;   // next state

  // true when the low bits of the divider are all ones
  function automatic logic tap(input logic [9:0] pre, input int bits);
    logic [9:0] m;
    m = 10'((11'h1 << bits) - 11'h1);
    return (pre & m) == m;
  endfunction

  // ----------------------------------------------------------------------
  // next state; the divider runs freely, so a new select takes effect
  // at the next tap rather than restarting the division
  // ----------------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    st_next.pre   = st_reg.pre + 10'h001;
    st_next.sync1 = ext_pin;
    st_next.sync2 = st_reg.sync1;
    st_next.last  = st_reg.sync2;
    unique case (clock_source_select)
      TCP_CSEL_STOP:    st_next.tick = 1'b0;
      TCP_CSEL_DIV1:    st_next.tick = 1'b1;
      TCP_CSEL_DIV8:    st_next.tick = tap(st_reg.pre, `TCP_DIV8_BITS);
      TCP_CSEL_DIV64:   st_next.tick = tap(st_reg.pre, `TCP_DIV64_BITS);
      TCP_CSEL_DIV256:  st_next.tick = tap(st_reg.pre, `TCP_DIV256_BITS);
      TCP_CSEL_DIV1024: st_next.tick = tap(st_reg.pre, `TCP_DIV1024_BITS);
      TCP_CSEL_FALL:    st_next.tick = st_reg.last & ~st_reg.sync2;
      TCP_CSEL_RISE:    st_next.tick = ~st_reg.last & st_reg.sync2;
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '{pre: `TCP_RST_PRESCALE, default: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign timer_tick = st_reg.tick;

endmodule // tcp_clock_select

// ### design/tcp_timer.sv
// eight bit timer with one compare channel and waveform generator
`timescale 1ns/1ns
`include "tcp_defs.svh"

// Summary of operation
// - count and compare are CPU readable bytes
// - tick from prescaler or external pin edge
// - select zero stops ticks, count frozen
// - detect bottom 0x00 and maximum 0xFF
// - top is 0xFF or compare by mode
// - each tick clears, increments or decrements count
// - count accessible with or without ticks
// - CPU count write beats clear or count
// - equal values match, flag on tick
// - compare irq needs flag, enable, global
// - writing one clears flag, zero ignored
// - overflow flag per mode, raises interrupt
// - compare double buffered only in PWM
// - compare writes go to buffer when buffered
// - force strobe drives output outside PWM modes, no flag
// - count write blocks next tick's match
// - output formed from match, max, bottom
// - output kept across mode changes
// - output action applies at once
// - normal mode wraps, overflow at zero
// - clear-on-match mode clears at compare
// - fast PWM single slope, set/clear output
// - action zero leaves output alone
module tcp_timer #(
  parameter int PRESCALE_WIDTH = 10  // prescaler length in bits
) (
  input  wire logic             MCLK,
  input  wire logic             RST,
  input  wire tcp_pkg::tcp_addr_t ADDR,
  input  wire tcp_pkg::tcp_byte_t WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output tcp_pkg::tcp_byte_t    RDATA,
  input  wire logic             EXT_COUNT_INPUT,
  input  wire logic             GLOBAL_IRQ_EN,
  input  wire logic             CMP_IRQ_ACK,
  input  wire logic             OVF_IRQ_ACK,
  output logic                  CMP_IRQ,
  output logic                  OVF_IRQ,
  output logic                  COMPARE_OUTPUT
);
  import tcp_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  if (PRESCALE_WIDTH != 10) begin : g_chk
    $error("prescaler must be ten bits wide");
  end

  // ----------------------------------------------------------------------
  // state of the whole block
  // ----------------------------------------------------------------------
  typedef struct packed {
    tcp_byte_t count;      // timer_count
    tcp_byte_t cmp_active; // compare value seen by the comparator
    tcp_byte_t cmp_buffer; // compare value as written by software
    tcp_csel_e csel;       // clock_source_select
    tcp_wave_e wave;       // waveform_mode_select
    logic [1:0] action;    // compare_output_action
    logic      dir_down;   // phase PWM currently counting down
    logic      block;      // next tick's match is suppressed
    logic      flag_ovf;   // overflow_flag
    logic      flag_cmp;   // compare_match_flag
    logic      mask_ovf;   // overflow irq enable
    logic      mask_cmp;   // compare_irq_enable
    logic      out;        // compare_output state
    logic      irq_cmp;    // registered compare request
    logic      irq_ovf;    // registered overflow request
    tcp_byte_t rdata;      // read data for the cycle after a read
  } tcp_state_s;

  tcp_state_s st_reg;      // registered state
  tcp_state_s st_next;     // next state

  // ----------------------------------------------------------------------
  // decoded helper signals
  // ----------------------------------------------------------------------
  logic      tick;         // timer_tick from clock select
  logic      pwm;          // a PWM mode is active
  logic      at_max;       // count is 0xff
  logic      at_bottom;    // count is 0x00
  tcp_byte_t top;          // highest value of the sequence
  logic      match;        // unblocked compare match on this tick
  logic      set_ovf;      // overflow event on this tick
  logic      wr_count;     // CPU writes the count
  logic      wr_cmp;       // CPU writes the compare value
  logic      wr_ctl;       // CPU writes the control byte
  logic      wr_flag;      // CPU writes the flag byte
  logic      wr_mask;      // CPU writes the mask byte
  tcp_wave_e new_wave;     // mode carried by a control write

  // ----------------------------------------------------------------------
  // tick source
  // ----------------------------------------------------------------------
  tcp_clock_select #(
    .PRESCALE_WIDTH (PRESCALE_WIDTH)
  ) u_csel (
    .mclk                (MCLK),
    .rst                 (RST),
    .clock_source_select (st_reg.csel),
    .ext_pin             (EXT_COUNT_INPUT),
    .timer_tick          (tick)
  );

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------

  // non-PWM match action: keep, toggle, clear or set
  function automatic logic act_plain(input logic cur,
                                     input logic [1:0] action);
    logic r;
    unique case (action)
      2'b00:   r = cur;
      2'b01:   r = ~cur;
      2'b10:   r = 1'b0;
      2'b11:   r = 1'b1;
    endcase
    return r;
  endfunction

  // PWM level for an event; the value 1 is reserved and acts as 0
  function automatic logic act_pwm(input logic cur,
                                   input logic [1:0] action,
                                   input logic level);
    logic r;
    unique case (action)
      2'b10:   r = level;
      2'b11:   r = ~level;
      default: r = cur;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // decode of the bus and of the count
  // ----------------------------------------------------------------------
  always_comb begin
    wr_count  = WR && (ADDR == `TCP_ADDR_COUNT);
    wr_cmp    = WR && (ADDR == `TCP_ADDR_COMPARE);
    wr_ctl    = WR && (ADDR == `TCP_ADDR_CONTROL);
    wr_flag   = WR && (ADDR == `TCP_ADDR_FLAG);
    wr_mask   = WR && (ADDR == `TCP_ADDR_MASK);
    new_wave  = tcp_wave_e'(WDATA[`TCP_CTL_WAVE_LSB +: 2]);
    pwm       = (st_reg.wave == TCP_WAVE_PHASE) ||
                (st_reg.wave == TCP_WAVE_FAST);
    at_max    = (st_reg.count == `TCP_MAX);
    at_bottom = (st_reg.count == `TCP_BOTTOM);
    // only clear-on-match takes its top from the compare value
    top       = (st_reg.wave == TCP_WAVE_CTC) ?
                st_reg.cmp_active : `TCP_MAX;
    // the comparator is always on; its result only counts on a tick
    match     = tick && !st_reg.block &&
                (st_reg.count == st_reg.cmp_active);
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    set_ovf = 1'b0;

    // ---- counting, on timer ticks only ----
    if (tick) begin
      // the blocking window lasts exactly one tick
      st_next.block = 1'b0;
      unique case (st_reg.wave)
        TCP_WAVE_NORMAL: begin
          // plain up count, wraps from max to bottom
          st_next.count    = st_reg.count + 8'h01;
          st_next.dir_down = 1'b0;
          set_ovf          = at_max;
        end
        TCP_WAVE_CTC: begin
          // clears on the match that reaches top
          if (match && (st_reg.count == top)) begin
            st_next.count = `TCP_BOTTOM;
          end else begin
            st_next.count = st_reg.count + 8'h01;
          end
          st_next.dir_down = 1'b0;
          set_ovf          = at_max;
        end
        TCP_WAVE_FAST: begin
          // single slope; the wrap from max is the bottom event
          st_next.count    = st_reg.count + 8'h01;
          st_next.dir_down = 1'b0;
          set_ovf          = at_max;
          if (at_max) begin
            st_next.cmp_active = st_reg.cmp_buffer;
          end
        end
        TCP_WAVE_PHASE: begin
          // dual slope; turns at max and at bottom
          if (!st_reg.dir_down) begin
            if (at_max) begin
              st_next.dir_down   = 1'b1;
              st_next.count      = st_reg.count - 8'h01;
              st_next.cmp_active = st_reg.cmp_buffer;
            end else begin
              st_next.count = st_reg.count + 8'h01;
            end
          end else begin
            if (at_bottom) begin
              st_next.dir_down = 1'b0;
              st_next.count    = st_reg.count + 8'h01;
              set_ovf          = 1'b1;
            end else begin
              st_next.count = st_reg.count - 8'h01;
            end
          end
        end
      endcase
    end

    // ---- waveform generator; action bits used as they stand ----
    unique case (st_reg.wave)
      TCP_WAVE_NORMAL, TCP_WAVE_CTC: begin
        if (match) begin
          st_next.out = act_plain(st_reg.out, st_reg.action);
        end
      end
      TCP_WAVE_FAST: begin
        // match clears in non-inverting use, bottom sets again;
        // bottom is applied last, so it wins when compare is max
        if (match) begin
          st_next.out = act_pwm(st_reg.out, st_reg.action, 1'b0);
        end
        if (tick && at_max) begin
          st_next.out = act_pwm(st_reg.out, st_reg.action, 1'b1);
        end
      end
      TCP_WAVE_PHASE: begin
        // clear on the up slope, set on the down slope
        if (match) begin
          st_next.out = act_pwm(st_reg.out, st_reg.action,
                                st_reg.dir_down);
        end
      end
    endcase

    // ---- software writes ----
    if (wr_count) begin
      // a write overrides any count or clear of the same cycle
      st_next.count = WDATA;
      st_next.block = 1'b1;
    end
    if (wr_cmp) begin
      st_next.cmp_buffer = WDATA;
      if (!pwm) begin
        // buffering bypassed outside the PWM modes
        st_next.cmp_active = WDATA;
      end
    end
    if (wr_ctl) begin
      // the output state is left as it is on a mode change
      st_next.csel   = tcp_csel_e'(WDATA[`TCP_CTL_CSEL_LSB +: 3]);
      st_next.wave   = new_wave;
      st_next.action = WDATA[`TCP_CTL_ACT_LSB +: 2];
      // force acts only when the written mode is a non-PWM one
      if (WDATA[`TCP_CTL_FORCE_BIT] &&
          (new_wave == TCP_WAVE_NORMAL || new_wave == TCP_WAVE_CTC)) begin
        st_next.out = act_plain(st_reg.out,
                                WDATA[`TCP_CTL_ACT_LSB +: 2]);
      end
      // leaving phase PWM must not leave the direction stuck down
      if (new_wave != TCP_WAVE_PHASE) begin
        st_next.dir_down = 1'b0;
      end
    end
    if (wr_mask) begin
      st_next.mask_ovf = WDATA[`TCP_FLAG_OVF_BIT];
      st_next.mask_cmp = WDATA[`TCP_FLAG_CMP_BIT];
    end

    // ---- flags: a set in the same cycle beats any clear ----
    st_next.flag_cmp = (st_reg.flag_cmp
                        & ~(wr_flag & WDATA[`TCP_FLAG_CMP_BIT])
                        & ~CMP_IRQ_ACK)
                       | match;
    st_next.flag_ovf = (st_reg.flag_ovf
                        & ~(wr_flag & WDATA[`TCP_FLAG_OVF_BIT])
                        & ~OVF_IRQ_ACK)
                       | set_ovf;

    // ---- interrupt requests ----
    st_next.irq_cmp = st_next.flag_cmp & st_next.mask_cmp
                      & GLOBAL_IRQ_EN;
    st_next.irq_ovf = st_next.flag_ovf & st_next.mask_ovf
                      & GLOBAL_IRQ_EN;

    // ---- read data, valid only in the cycle after the strobe ----
    st_next.rdata = 8'h00;
    if (RD) begin
      unique case (ADDR)
        `TCP_ADDR_COUNT:   st_next.rdata = st_reg.count;
        // while buffered the buffer is what software sees
        `TCP_ADDR_COMPARE: st_next.rdata = st_reg.cmp_buffer;
        `TCP_ADDR_CONTROL: st_next.rdata = {1'b0, st_reg.action,
                                            st_reg.wave, st_reg.csel};
        `TCP_ADDR_FLAG:    st_next.rdata = {6'h00, st_reg.flag_cmp,
                                            st_reg.flag_ovf};
        `TCP_ADDR_MASK:    st_next.rdata = {6'h00, st_reg.mask_cmp,
                                            st_reg.mask_ovf};
        default:           st_next.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_reg <= '{count:      `TCP_RST_BYTE,
                  cmp_active: `TCP_RST_BYTE,
                  cmp_buffer: `TCP_RST_BYTE,
                  csel:       TCP_CSEL_STOP,
                  wave:       TCP_WAVE_NORMAL,
                  rdata:      `TCP_RST_BYTE,
                  default:    1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------------
  assign RDATA          = st_reg.rdata;
  assign CMP_IRQ        = st_reg.irq_cmp;
  assign OVF_IRQ        = st_reg.irq_ovf;
  assign COMPARE_OUTPUT = st_reg.out;

endmodule // tcp_timer

// ### testbench/tcp_timer_properties.sv
// concurrent checks on the timer's register port and interrupt requests
`timescale 1ns/1ns
`include "tcp_defs.svh"
module tcp_timer_properties (
  input wire logic               MCLK,
  input wire logic               RST,
  input wire tcp_pkg::tcp_addr_t ADDR,
  input wire tcp_pkg::tcp_byte_t WDATA,
  input wire logic               WR,
  input wire logic               RD,
  input wire tcp_pkg::tcp_byte_t RDATA,
  input wire logic               GLOBAL_IRQ_EN,
  input wire logic               CMP_IRQ,
  input wire logic               OVF_IRQ
);
  import tcp_pkg::*;
  // ----------------------------------------------------------------
  // shadow of the compare mask bit as software last wrote it
  // ----------------------------------------------------------------
  logic mask_reg;
  always_ff @(posedge MCLK) begin
    if (RST) mask_reg <= 1'b0;
    else if (WR && ADDR == `TCP_ADDR_MASK)
      mask_reg <= WDATA[`TCP_FLAG_CMP_BIT];
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------
  // read port and interrupt gating
  // ----------------------------------------------------------------
  chk_count_readback: assert property (
    WR && ADDR == 3'h0 ##1 RD && ADDR == 3'h0 |=> RDATA == $past(WDATA, 2))
    else $error("count read differs from value written");
  chk_compare_readback: assert property (
    WR && ADDR == 3'h1 ##1 RD && ADDR == 3'h1 |=> RDATA == $past(WDATA, 2))
    else $error("compare read differs from value written");
  chk_flag_reserved: assert property (
    RD && ADDR == 3'h3 |=> RDATA[7:2] == 6'h00)
    else $error("unused flag bits read nonzero");
  chk_force_hidden: assert property (
    RD && ADDR == 3'h2 |=> !RDATA[7]) else $error("force bit reads one");
  chk_unmapped_zero: assert property (
    RD && ADDR > 3'h4 |=> RDATA == 8'h00) else $error("unmapped read nonzero");
  chk_rdata_quiet: assert property (
    !$past(RD) |-> RDATA == 8'h00) else $error("read data without read");
  chk_global_gate: assert property (
    !$past(GLOBAL_IRQ_EN) |-> !CMP_IRQ && !OVF_IRQ)
    else $error("request while global enable low");
  chk_mask_gate: assert property (
    !mask_reg |-> !CMP_IRQ) else $error("compare request while masked");
endmodule // tcp_timer_properties

bind tcp_timer tcp_timer_properties u_tcp_timer_properties (
  .MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .CMP_IRQ(CMP_IRQ),
  .OVF_IRQ(OVF_IRQ));

// ### testbench/tcp_cpu_model.sv
// core side: takes pending timer interrupts and reports them executed
`timescale 1ns/1ns
module tcp_cpu_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en,
  input  wire logic cmp_irq,
  input  wire logic ovf_irq,
  output logic      cmp_ack,
  output logic      ovf_ack
);
  // one-cycle acknowledge; compare wins when both are pending
  always_ff @(posedge clk) begin
    cmp_ack <= !rst && en && cmp_irq && !cmp_ack;
    ovf_ack <= !rst && en && ovf_irq && !ovf_ack && !cmp_irq;
  end
endmodule // tcp_cpu_model

// ### testbench/tcp_timer_tb.sv
// self-checking bench for the eight bit timer
`timescale 1ns/1ns
`include "tcp_defs.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  err_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tcp_timer_tb;
  import tcp_pkg::*;
  localparam tcp_addr_t a_cnt = `TCP_ADDR_COUNT;   // count byte
  localparam tcp_addr_t a_cmp = `TCP_ADDR_COMPARE; // compare byte
  localparam tcp_addr_t a_ctl = `TCP_ADDR_CONTROL; // control byte
  localparam tcp_addr_t a_flg = `TCP_ADDR_FLAG;    // flag byte
  localparam tcp_addr_t a_msk = `TCP_ADDR_MASK;    // mask byte
  logic      MCLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
  logic      EXT_COUNT_INPUT = 1'b0, GLOBAL_IRQ_EN = 1'b0, ack_en = 1'b0;
  tcp_addr_t ADDR = 3'h0;
  tcp_byte_t WDATA = 8'h00, RDATA, v, q;
  logic      CMP_IRQ_ACK, OVF_IRQ_ACK, CMP_IRQ, OVF_IRQ, COMPARE_OUTPUT;
  logic      seen_cmp = 1'b0, seen_ovf = 1'b0; // request ever seen high
  int        err_count = 0, n_compared = 0, cyc_n = 0;
  always #2 MCLK = ~MCLK;
  tcp_timer #(.PRESCALE_WIDTH(10)) u_tcp_timer (
    .MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .EXT_COUNT_INPUT(EXT_COUNT_INPUT),
    .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .CMP_IRQ_ACK(CMP_IRQ_ACK),
    .OVF_IRQ_ACK(OVF_IRQ_ACK), .CMP_IRQ(CMP_IRQ), .OVF_IRQ(OVF_IRQ),
    .COMPARE_OUTPUT(COMPARE_OUTPUT));
  tcp_cpu_model u_tcp_cpu_model (
    .clk(MCLK), .rst(RST), .en(ack_en), .cmp_irq(CMP_IRQ),
    .ovf_irq(OVF_IRQ), .cmp_ack(CMP_IRQ_ACK), .ovf_ack(OVF_IRQ_ACK));
  // ----------------------------------------------------------------
  // request monitor and hang guard
  // ----------------------------------------------------------------
  always @(posedge MCLK) begin
    if (CMP_IRQ === 1'b1) seen_cmp <= 1'b1;
    if (OVF_IRQ === 1'b1) seen_ovf <= 1'b1;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_count++;
      final_report();
    end
  end
  // one bus cycle: strobes held through exactly one rising edge
  task automatic bus(input logic w, r, input tcp_addr_t a, tcp_byte_t d);
    WR <= w;
    RD <= r;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
  endtask
  task automatic wr(input tcp_addr_t a, input tcp_byte_t d);
    bus(1'b1, 1'b0, a, d);
  endtask
  // data stands only in the cycle after the strobe; taken before it goes
  task automatic rd(input tcp_addr_t a, output tcp_byte_t d);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    d = RDATA;
  endtask
  task automatic cyc(input int n);
    repeat (n) bus(1'b0, 1'b0, 3'h0, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), v);
      `CHK("reset value", 8'h00, v)
    end
    wr(a_cnt, 8'h5a);
    rd(a_cnt, v);
    `CHK("count", 8'h5a, v)
    wr(a_cmp, 8'ha5);
    rd(a_cmp, v);
    `CHK("compare", 8'ha5, v)
    wr(3'h6, 8'hff);
    rd(3'h6, v);
    `CHK("unmapped", 8'h00, v)
  endtask
  // normal mode wrap past a match, then write-one clearing
  task automatic t_normal();
    wr(a_cmp, 8'h02);
    wr(a_cnt, 8'hfd);
    wr(a_ctl, 8'h01);
    cyc(12);
    wr(a_ctl, 8'h00);
    rd(a_flg, v);
    `CHK("flags after wrap", 8'h03, v)
    wr(a_flg, 8'h00);
    rd(a_flg, v);
    `CHK("zero write", 8'h03, v)
    wr(a_flg, 8'h01);
    rd(a_flg, v);
    `CHK("clear overflow", 8'h02, v)
    wr(a_flg, 8'h02);
    rd(a_flg, v);
    `CHK("clear match", 8'h00, v)
  endtask
  // count written equal to compare: first match lost; stopped stays put
  task automatic t_block();
    wr(a_cmp, 8'h05);
    wr(a_cnt, 8'h05);
    wr(a_ctl, 8'h01);
    cyc(8);
    wr(a_ctl, 8'h00);
    rd(a_flg, v);
    `CHK("blocked match", 8'h00, v)
    rd(a_cnt, q);
    cyc(20);
    rd(a_cnt, v);
    `CHK("stopped count", q, v)
  endtask
  task automatic t_ctc();
    wr(a_cmp, 8'h03);
    wr(a_cnt, 8'h00);
    wr(a_ctl, 8'h11);
    cyc(30);
    wr(a_ctl, 8'h10);
    rd(a_cnt, v);
    `CHK("count at most top", 1'b1, v <= 8'h03)
    rd(a_flg, v);
    `CHK("match, no overflow", 8'h02, v)
    wr(a_flg, 8'h03);
  endtask
  // forced actions while stopped; no flag, no count change
  task automatic t_force();
    tcp_byte_t ctl [5] = '{8'he0, 8'hc0, 8'ha0, 8'h80, 8'hd8};
    logic      exp [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    rd(a_cnt, q);
    for (int i = 0; i < 5; i++) begin
      wr(a_ctl, ctl[i]);
      cyc(1);
      `CHK("forced output", exp[i], COMPARE_OUTPUT)
    end
    rd(a_flg, v);
    `CHK("flag after force", 8'h00, v)
    rd(a_cnt, v);
    `CHK("count after force", q, v)
    wr(a_ctl, 8'h00);
  endtask
  // overflow taken by the core; compare masked then released
  task automatic t_irq();
    wr(a_msk, 8'h01);
    GLOBAL_IRQ_EN <= 1'b1;
    ack_en <= 1'b1;
    wr(a_cmp, 8'h02);
    wr(a_cnt, 8'hfe);
    wr(a_ctl, 8'h01);
    cyc(12);
    wr(a_ctl, 8'h00);
    cyc(4);
    `CHK("overflow request", 1'b1, seen_ovf)
    `CHK("masked compare", 1'b0, seen_cmp)
    rd(a_flg, v);
    `CHK("flags after ack", 8'h02, v)
    wr(a_msk, 8'h02);
    cyc(6);
    `CHK("compare request", 1'b1, seen_cmp)
    rd(a_flg, v);
    `CHK("compare acked", 8'h00, v)
  endtask
  // external rising edges counted; pin waits out the synchroniser
  task automatic t_ext();
    wr(a_cnt, 8'h00);
    wr(a_ctl, 8'h07);
    repeat (3) begin
      EXT_COUNT_INPUT <= 1'b1;
      cyc(8);
      EXT_COUNT_INPUT <= 1'b0;
      cyc(8);
    end
    wr(a_ctl, 8'h06); // one more pulse, counted on its falling edge
    EXT_COUNT_INPUT <= 1'b1;
    cyc(8);
    EXT_COUNT_INPUT <= 1'b0;
    cyc(8);
    wr(a_ctl, 8'h00);
    rd(a_cnt, v);
    `CHK("external edges", 8'h04, v)
  endtask
  // fast PWM: compare held in the buffer until the wrap, then used
  task automatic t_pwm();
    wr(a_ctl, 8'h58);
    wr(a_cmp, 8'hf8);
    wr(a_cnt, 8'hf0);
    wr(a_ctl, 8'h59);
    cyc(12);
    `CHK("buffered compare", 1'b1, COMPARE_OUTPUT)
    cyc(256);
    `CHK("cleared on match", 1'b0, COMPARE_OUTPUT)
    wr(a_ctl, 8'h00);
  endtask
  task automatic final_report();
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge MCLK);
    RST <= 1'b0;
    t_regs();
    t_normal();
    t_block();
    t_ctc();
    t_force();
    t_irq();
    t_ext();
    t_pwm();
    final_report();
  end
endmodule // tcp_timer_tb
